// ---- dual_loop_channel_synthesizer.sv ----
// Purpose: Dual-loop channel synthesizer core with AXI4-Lite status and control.
// Assumes: VCO and reference pins toggle well below a quarter of the system clock.
// Notes: Pin edges are seen only after the three-flop synchroniser settles.
//
// Added by the designer: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
module dual_loop_channel_synthesizer
  import dual_synth_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // Channel select pins
  input wire logic i_mode,
  input wire logic i_standby_ctl,
  input wire logic [3:0] i_chan_code,
  input wire logic i_ser_clk,
  input wire logic i_ser_data,
  input wire logic i_latch_strobe,
  // Oscillator and VCO pins
  input wire logic i_ref_osc_in,
  input wire logic i_rx_vco_in,
  input wire logic i_tx_vco_in,
  output logic o_ref_osc_out,
  // Phase detector pins
  output logic o_phase_err_a_out,
  output logic o_phase_err_a_oe,
  output logic o_phase_err_b_out,
  output logic o_phase_err_b_oe,
  // Open-drain status pins
  output logic o_out_of_lock_flag_out,
  output logic o_out_of_lock_flag_oe,
  output logic o_tone_out,
  output logic o_tone_oe,
  // AXI4-Lite slave
  input wire logic [ADDR_W-1:0] i_s_axi_awaddr,
  input wire logic i_s_axi_awvalid,
  output logic o_s_axi_awready,
  input wire logic [31:0] i_s_axi_wdata,
  input wire logic [3:0] i_s_axi_wstrb,
  input wire logic i_s_axi_wvalid,
  output logic o_s_axi_wready,
  output logic [1:0] o_s_axi_bresp,
  output logic o_s_axi_bvalid,
  input wire logic i_s_axi_bready,
  input wire logic [ADDR_W-1:0] i_s_axi_araddr,
  input wire logic i_s_axi_arvalid,
  output logic o_s_axi_arready,
  output logic [31:0] o_s_axi_rdata,
  output logic [1:0] o_s_axi_rresp,
  output logic o_s_axi_rvalid,
  input wire logic i_s_axi_rready
);
  // ==========================================================================
  // Pin synchronisers
  logic [PIN_N-1:0] pin_raw;
  logic [PIN_N-1:0] s1_r;
  logic [PIN_N-1:0] s2_r;
  logic [PIN_N-1:0] s3_r;
  logic [PIN_N-1:0] pin_r;
  logic [PIN_N-1:0] rise;

  assign pin_raw = {i_ref_osc_in, i_tx_vco_in, i_rx_vco_in, i_latch_strobe, i_ser_data, i_ser_clk,
                    i_chan_code, i_standby_ctl, i_mode};

  // Each pin counts as changed once the second and third stages agree.
  genvar g;
  for (g = 0; g < PIN_N; g++) begin : g_sync
    logic stable_nxt;
    always_comb begin
      stable_nxt = (s2_r[g] == s3_r[g]) ? s3_r[g] : pin_r[g];
    end
    always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
        s1_r[g] <= 1'b0;
        s2_r[g] <= 1'b0;
        s3_r[g] <= 1'b0;
        pin_r[g] <= 1'b0;
      end else begin
        s1_r[g] <= pin_raw[g];
        s2_r[g] <= s1_r[g];
        s3_r[g] <= s2_r[g];
        pin_r[g] <= stable_nxt;
      end
    end
    assign rise[g] = stable_nxt & ~pin_r[g];
  end

  // ==========================================================================
  // Core state
  logic serial_sel_r, serial_sel_nxt;
  logic [3:0] shreg_r, shreg_nxt;
  logic [3:0] ser_latch_r, ser_latch_nxt;
  logic [DIV_W-1:0] tx_div_r, tx_div_nxt;
  logic [DIV_W-1:0] rx_div_r, rx_div_nxt;
  logic tone_r, tone_nxt;
  logic tone_oe_r, tone_oe_nxt;
  logic cmp_phase_r, cmp_phase_nxt;
  logic cmp_ev_r, cmp_ev_nxt;
  logic osc_out_r, osc_out_nxt;
  logic [LOCK_W-1:0] err_cnt_r, err_cnt_nxt;
  logic lock_bad_r, lock_bad_nxt;
  logic [3:0] code_sel;
  logic [3:0] chan_eff;
  logic [3:0] tbl_idx;
  logic ref_tc, rx_tc, tx_tc;
  logic tx_run;
  logic tx_pd_oe;

  assign tx_run = pin_r[PIN_STBY];

  // Dividers: one shared reference path, one counter per VCO input.
  divn_counter #(.W(REF_W)) u_ref_div (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_en(1'b1), .i_step(rise[PIN_REF]),
    .i_div(REF_W'(TONE_HALF)), .o_tc(ref_tc)
  );
  divn_counter #(.W(DIV_W)) u_rx_div (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_en(1'b1), .i_step(rise[PIN_RXV]),
    .i_div(rx_div_r), .o_tc(rx_tc)
  );
  divn_counter #(.W(DIV_W)) u_tx_div (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_en(tx_run), .i_step(rise[PIN_TXV]),
    .i_div(tx_div_r), .o_tc(tx_tc)
  );

  // Phase detectors: a on the receive loop, b on the transmit loop.
  pfd_tristate u_pd_rx (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_en(1'b1), .i_ref_ev(cmp_ev_r), .i_vco_ev(rx_tc),
    .o_pd_out(o_phase_err_a_out), .o_pd_oe(o_phase_err_a_oe)
  );
  pfd_tristate u_pd_tx (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_en(tx_run), .i_ref_ev(cmp_ev_r), .i_vco_ev(tx_tc),
    .o_pd_out(o_phase_err_b_out), .o_pd_oe(tx_pd_oe)
  );
  assign o_phase_err_b_oe = tx_pd_oe;

  // Channel decode: invalid codes fall back to channel ten.
  assign code_sel = serial_sel_r ? ser_latch_r : pin_r[PIN_CODE +: 4];
  assign chan_eff = (code_sel >= CHAN_MIN && code_sel <= CHAN_MAX) ? code_sel : CHAN_DEFAULT;
  assign tbl_idx = chan_eff - 4'h1;

  // Next state of the channel path, tone, comparison and lock logic.
  always_comb begin
    shreg_nxt = shreg_r;
    ser_latch_nxt = ser_latch_r;
    if (rise[PIN_SCLK]) begin
      shreg_nxt = {shreg_r[2:0], pin_r[PIN_SDAT]};
    end
    if (rise[PIN_STRB]) begin
      ser_latch_nxt = shreg_r;
    end
    tx_div_nxt = pin_r[PIN_MODE] ? TX_BS[tbl_idx] : TX_HS[tbl_idx];
    rx_div_nxt = pin_r[PIN_MODE] ? RX_BS[tbl_idx] : RX_HS[tbl_idx];
    // Tone toggles every half period; comparison fires on every second toggle.
    tone_nxt = tone_r ^ ref_tc;
    tone_oe_nxt = ~tone_nxt;
    cmp_phase_nxt = cmp_phase_r ^ ref_tc;
    cmp_ev_nxt = ref_tc & cmp_phase_r;
    osc_out_nxt = ~pin_r[PIN_REF];
    // Lock is judged by how long each transmit error pulse lasts.
    err_cnt_nxt = err_cnt_r;
    lock_bad_nxt = lock_bad_r;
    if (!tx_run) begin
      err_cnt_nxt = '0;
      lock_bad_nxt = 1'b0;
    end else if (tx_pd_oe) begin
      if (err_cnt_r < LOCK_W'(LOCK_TOL_CYC)) begin
        err_cnt_nxt = err_cnt_r + 1'b1;
      end else begin
        lock_bad_nxt = 1'b1;
      end
    end else if (err_cnt_r != '0) begin
      lock_bad_nxt = err_cnt_r >= LOCK_W'(LOCK_TOL_CYC);
      err_cnt_nxt = '0;
    end
  end

  // Register the core state.
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      shreg_r <= '0;
      ser_latch_r <= '0;
      tx_div_r <= TX_HS[9];
      rx_div_r <= RX_HS[9];
      tone_r <= 1'b0;
      tone_oe_r <= 1'b1;
      cmp_phase_r <= 1'b0;
      cmp_ev_r <= 1'b0;
      osc_out_r <= 1'b1;
      err_cnt_r <= '0;
      lock_bad_r <= 1'b0;
    end else begin
      shreg_r <= shreg_nxt;
      ser_latch_r <= ser_latch_nxt;
      tx_div_r <= tx_div_nxt;
      rx_div_r <= rx_div_nxt;
      tone_r <= tone_nxt;
      tone_oe_r <= tone_oe_nxt;
      cmp_phase_r <= cmp_phase_nxt;
      cmp_ev_r <= cmp_ev_nxt;
      osc_out_r <= osc_out_nxt;
      err_cnt_r <= err_cnt_nxt;
      lock_bad_r <= lock_bad_nxt;
    end
  end

  // P-channel pin pulls high only when out of lock; N-channel tone pulls low.
  assign o_out_of_lock_flag_out = lock_bad_r;
  assign o_out_of_lock_flag_oe = lock_bad_r;
  assign o_tone_out = tone_r;
  assign o_tone_oe = tone_oe_r;
  assign o_ref_osc_out = osc_out_r;

  // ==========================================================================
  // AXI4-Lite slave
  logic aw_held_r, aw_held_nxt, w_held_r, w_held_nxt;
  logic [ADDR_W-1:0] awaddr_r, awaddr_nxt;
  logic [31:0] wdata_r, wdata_nxt;
  logic wstrb0_r, wstrb0_nxt;
  logic awready_r, awready_nxt, wready_r, wready_nxt;
  logic bvalid_r, bvalid_nxt, arready_r, arready_nxt, rvalid_r, rvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;

  // Address and data are held separately, so either may arrive first.
  always_comb begin
    aw_held_nxt = aw_held_r;
    awaddr_nxt = awaddr_r;
    w_held_nxt = w_held_r;
    wdata_nxt = wdata_r;
    wstrb0_nxt = wstrb0_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    serial_sel_nxt = serial_sel_r;
    if (bvalid_r && i_s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
    if (i_s_axi_awvalid && awready_r) begin
      aw_held_nxt = 1'b1;
      awaddr_nxt = i_s_axi_awaddr;
    end
    if (i_s_axi_wvalid && wready_r) begin
      w_held_nxt = 1'b1;
      wdata_nxt = i_s_axi_wdata;
      wstrb0_nxt = i_s_axi_wstrb[0];
    end
    if (aw_held_nxt && w_held_nxt && !bvalid_r) begin
      aw_held_nxt = 1'b0;
      w_held_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = RESP_OKAY;
      unique case (awaddr_nxt)
        REG_CTRL: begin
          if (wstrb0_nxt) begin
            serial_sel_nxt = wdata_nxt[0];
          end
        end
        REG_STATUS, REG_DIV: begin
        end
        default: bresp_nxt = RESP_SLVERR;
      endcase
    end
    awready_nxt = !aw_held_nxt && !bvalid_nxt;
    wready_nxt = !w_held_nxt && !bvalid_nxt;
    // One read at a time; the answer comes one cycle after the address.
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    if (rvalid_r && i_s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
    if (i_s_axi_arvalid && arready_r) begin
      rvalid_nxt = 1'b1;
      rresp_nxt = RESP_OKAY;
      unique case (i_s_axi_araddr)
        REG_CTRL: rdata_nxt = {31'h0, serial_sel_r};
        REG_STATUS: rdata_nxt = {21'h0, pin_r[PIN_MODE], tx_run, lock_bad_r, chan_eff, code_sel};
        REG_DIV: rdata_nxt = {2'h0, tx_div_r, 2'h0, rx_div_r};
        default: begin
          rdata_nxt = 32'h0;
          rresp_nxt = RESP_SLVERR;
        end
      endcase
    end
    arready_nxt = !rvalid_nxt;
  end

  // Register the bus state.
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      aw_held_r <= 1'b0;
      awaddr_r <= '0;
      w_held_r <= 1'b0;
      wdata_r <= '0;
      wstrb0_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      serial_sel_r <= CTRL_SERIAL_RST;
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= RESP_OKAY;
    end else begin
      aw_held_r <= aw_held_nxt;
      awaddr_r <= awaddr_nxt;
      w_held_r <= w_held_nxt;
      wdata_r <= wdata_nxt;
      wstrb0_r <= wstrb0_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      serial_sel_r <= serial_sel_nxt;
      awready_r <= awready_nxt;
      wready_r <= wready_nxt;
      arready_r <= arready_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
    end
  end

  assign o_s_axi_awready = awready_r;
  assign o_s_axi_wready = wready_r;
  assign o_s_axi_bvalid = bvalid_r;
  assign o_s_axi_bresp = bresp_r;
  assign o_s_axi_arready = arready_r;
  assign o_s_axi_rvalid = rvalid_r;
  assign o_s_axi_rdata = rdata_r;
  assign o_s_axi_rresp = rresp_r;

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  AST_TX_STANDBY_OFF: assert property (!tx_run |=> !tx_pd_oe)
    else $error("transmit detector active in standby");
  AST_BAD_CODE_CH10: assert property ((code_sel == 4'h0 || code_sel > CHAN_MAX) && !pin_r[PIN_MODE]
    |=> tx_div_r == 14'h270A && rx_div_r == 14'h1C57)
    else $error("invalid code did not select channel ten");
  AST_CH1_HANDSET: assert property (code_sel == 4'h1 && !pin_r[PIN_MODE]
    |=> tx_div_r == 14'h26CE && rx_div_r == 14'h1C0F)
    else $error("channel one handset divisors wrong");
  AST_CH3_BASE: assert property (code_sel == 4'h3 && pin_r[PIN_MODE]
    |=> tx_div_r == 14'h2476 && rx_div_r == 14'h1E99)
    else $error("channel three base divisors wrong");
  AST_SHIFT_IN: assert property (rise[PIN_SCLK]
    |=> shreg_r == {$past(shreg_r[2:0]), $past(pin_r[PIN_SDAT])})
    else $error("serial bit not shifted in");
  AST_LATCH_COPY: assert property (rise[PIN_STRB] && !rise[PIN_SCLK] |=> ser_latch_r == $past(shreg_r))
    else $error("latch strobe did not copy shift register");
  AST_LOCK_FLAG: assert property (tx_run && tx_pd_oe && err_cnt_r == LOCK_W'(LOCK_TOL_CYC)
    |=> ##[0:1] o_out_of_lock_flag_oe)
    else $error("long transmit error not flagged");
  AST_TONE_EDGE: assert property ($changed(tone_r) |-> $past(ref_tc) && o_tone_oe == !tone_r)
    else $error("tone moved without a reference half period");
  AST_CMP_EVERY_OTHER: assert property (cmp_ev_r |-> !cmp_phase_r ##1 !cmp_ev_r)
    else $error("comparison pulse rate wrong");
endmodule

// ---- dual_synth_pkg.sv ----
// Purpose: Shared constants for the dual-loop channel synthesizer core.
// Assumes: One 25 MHz system clock; every pin is sampled through a synchroniser.
// Notes: Divisor tables are indexed by channel number minus one.
// Function
// - The mode pin steers divisor decoding, high for base and low for handset, and defaults low.
// - Standby high runs both loops, standby low stops the transmit loop and keeps the receive loop.
// - The parallel variant takes a four-bit BCD channel code from pins that default low.
// - Any code outside channels one to ten selects channel ten for both loops.
// - The receive VCO input clocks the receive counter and the transmit VCO input the transmit counter.
// - Channel one divides by 9934/7183 in handset mode and 9322/7795 in base mode.
// - Channel two divides by 9969/7187 or 9326/7830, channel three by 9972/7195 or 9334/7833.
// - Each rising serial clock shifts one data bit in, a high level being a one.
// - A positive latch strobe copies the shift register into the four-bit channel latch.
// - The out-of-lock flag follows only the transmit loop and is a P-channel open-drain output.
// - Each phase detector pulses low when the VCO leads, high when it lags, and floats when aligned.
// - A 5 kHz tone derived from the reference drives an N-channel open-drain output.
// - One reference path from the oscillator input feeds both phase detectors.
package dual_synth_pkg;
  // ==========================================================================
  // Rates and dividers
  localparam int CLK_HZ = 25_000_000;
  localparam int REF_OSC_HZ = 10_240_000;
  localparam int CMP_HZ = 5_000;
  localparam int REF_DIV = REF_OSC_HZ / CMP_HZ;
  localparam int TONE_HALF = REF_DIV / 2;
  localparam int REF_W = 12;
  localparam int DIV_W = 14;
  localparam int LOCK_TOL_NS = 320;
  localparam int LOCK_TOL_CYC = (LOCK_TOL_NS * (CLK_HZ / 1_000_000)) / 1000;
  localparam int LOCK_W = 4;
  // ==========================================================================
  // Pin synchroniser slots
  localparam int PIN_N = 12;
  localparam int PIN_MODE = 0;
  localparam int PIN_STBY = 1;
  localparam int PIN_CODE = 2;
  localparam int PIN_SCLK = 6;
  localparam int PIN_SDAT = 7;
  localparam int PIN_STRB = 8;
  localparam int PIN_RXV = 9;
  localparam int PIN_TXV = 10;
  localparam int PIN_REF = 11;
  // ==========================================================================
  // Channel decode
  localparam logic [3:0] CHAN_MIN = 4'h1;
  localparam logic [3:0] CHAN_MAX = 4'hA;
  localparam logic [3:0] CHAN_DEFAULT = 4'hA;
  localparam logic [DIV_W-1:0] TX_HS [0:9] = '{14'h26CE, 14'h26F1, 14'h26F4, 14'h26E2, 14'h26F7,
                                               14'h26EE, 14'h26FA, 14'h2702, 14'h270E, 14'h270A};
  localparam logic [DIV_W-1:0] RX_HS [0:9] = '{14'h1C0F, 14'h1C13, 14'h1C1B, 14'h1C23, 14'h1C27,
                                               14'h1C2F, 14'h1C3B, 14'h1C43, 14'h1C4F, 14'h1C57};
  localparam logic [DIV_W-1:0] TX_BS [0:9] = '{14'h246A, 14'h246E, 14'h2476, 14'h247E, 14'h2482,
                                               14'h248A, 14'h2496, 14'h249E, 14'h24AA, 14'h24B2};
  localparam logic [DIV_W-1:0] RX_BS [0:9] = '{14'h1E73, 14'h1E96, 14'h1E99, 14'h1E87, 14'h1E9C,
                                               14'h1E93, 14'h1E9F, 14'h1EA7, 14'h1EB3, 14'h1EAF};
  // ==========================================================================
  // Register map
  localparam int ADDR_W = 8;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_DIV = 8'h08;
  localparam logic CTRL_SERIAL_RST = 1'b0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ---- divn_counter.sv ----
// Purpose: Programmable divide-by-N counter stepped by input edge pulses.
// Assumes: i_step is a one-cycle pulse on the system clock.
// Notes: Holds at zero while disabled so a restart begins a full cycle.
`timescale 1ns/1ps
module divn_counter #(
  parameter int W = 14
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // Control
  input wire logic i_en,
  input wire logic i_step,
  input wire logic [W-1:0] i_div,
  // Divided pulse
  output logic o_tc
);
  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;
  logic tc_r;
  logic tc_nxt;

  // Count input edges and reload at terminal count.
  always_comb begin
    cnt_nxt = cnt_r;
    tc_nxt = 1'b0;
    if (!i_en) begin
      cnt_nxt = '0;
    end else if (i_step) begin
      if (cnt_r >= i_div - 1'b1) begin
        cnt_nxt = '0;
        tc_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r + 1'b1;
      end
    end
  end

  // Register the counter state.
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      cnt_r <= '0;
      tc_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      tc_r <= tc_nxt;
    end
  end

  assign o_tc = tc_r;
endmodule

// ---- pfd_tristate.sv ----
// Purpose: Three-state phase-frequency detector for one loop.
// Assumes: Reference and VCO events are one-cycle pulses on the system clock.
// Notes: Drive level high means pump up, low means pump down.
`timescale 1ns/1ps
module pfd_tristate (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // Events
  input wire logic i_en,
  input wire logic i_ref_ev,
  input wire logic i_vco_ev,
  // Pin drive
  output logic o_pd_out,
  output logic o_pd_oe
);
  logic up_r;
  logic dn_r;
  logic oe_r;
  logic up_nxt;
  logic dn_nxt;

  // Whichever edge comes first opens its side; the other edge closes both.
  always_comb begin
    up_nxt = up_r | i_ref_ev;
    dn_nxt = dn_r | i_vco_ev;
    if ((up_nxt && dn_nxt) || !i_en) begin
      up_nxt = 1'b0;
      dn_nxt = 1'b0;
    end
  end

  // Register the pump state and its enable.
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      up_r <= 1'b0;
      dn_r <= 1'b0;
      oe_r <= 1'b0;
    end else begin
      up_r <= up_nxt;
      dn_r <= dn_nxt;
      oe_r <= up_nxt | dn_nxt;
    end
  end

  assign o_pd_out = up_r;
  assign o_pd_oe = oe_r;
endmodule

// ---- synth_partner.sv ----
// Purpose: Controller and VCO stand-in that drives the synthesizer pins.
// Assumes: Every pin changes right after a rising edge of i_clk.
// Notes: Each level is held at least three cycles so the pin synchroniser never misses it.
`timescale 1ns/1ps
module synth_partner #(
  parameter int REF_HALF = 3
) (
  // Clock
  input wire logic i_clk,
  // Bench controls
  input wire logic i_rx_run,
  input wire logic i_tx_run,
  // Pins toward the synthesizer
  output logic o_ref_osc,
  output logic o_rx_vco,
  output logic o_tx_vco,
  output logic o_ser_clk,
  output logic o_ser_data,
  output logic o_strobe
);
  int ref_cnt = 0;
  // ==========================================================================
  // Oscillators
  // One reference toggles on a fixed count; the VCOs follow its pace when run.
  initial begin
    {o_ref_osc, o_rx_vco, o_tx_vco, o_ser_clk, o_ser_data, o_strobe} = 6'h00;
  end
  always @(posedge i_clk) begin
    ref_cnt <= (ref_cnt == REF_HALF - 1) ? 0 : ref_cnt + 1;
    if (ref_cnt == REF_HALF - 1) begin
      o_ref_osc <= ~o_ref_osc;
    end
    if (ref_cnt == 0 && i_rx_run) begin
      o_rx_vco <= ~o_rx_vco;
    end
    if (ref_cnt == 0 && i_tx_run) begin
      o_tx_vco <= ~o_tx_vco;
    end
  end
  // ==========================================================================
  // Serial controller
  // Sends five bits oldest first, so the first one must be pushed out.
  task automatic send_code(input logic [4:0] bits);
    for (int i = 4; i >= 0; i--) begin
      o_ser_data <= bits[i];
      repeat (4) @(posedge i_clk);
      o_ser_clk <= 1'b1;
      repeat (4) @(posedge i_clk);
      o_ser_clk <= 1'b0;
      repeat (4) @(posedge i_clk);
    end
    // Data past its hold time shows the inverse, not a stale level.
    o_ser_data <= ~bits[0];
    o_strobe <= 1'b1;
    repeat (4) @(posedge i_clk);
    o_strobe <= 1'b0;
    repeat (4) @(posedge i_clk);
  endtask
endmodule

// ---- test_dual_loop_channel_synthesizer.sv ----
// Purpose: Self-checking bench for the dual-loop channel synthesizer.
// Assumes: The partner model drives reference, VCO and serial pins.
// Notes: VCOs never finish a count, so only the lagging detector state is seen.
`timescale 1ns/1ps
module test_dual_loop_channel_synthesizer import dual_synth_pkg::*;;
  logic i_clk, i_sys_rst, i_mode, i_standby_ctl, i_ser_clk, i_ser_data, i_latch_strobe;
  logic i_ref_osc_in, i_rx_vco_in, i_tx_vco_in, rx_run, tx_run;
  logic [3:0] i_chan_code, i_s_axi_wstrb;
  logic o_ref_osc_out, o_phase_err_a_out, o_phase_err_a_oe, o_phase_err_b_out, o_phase_err_b_oe;
  logic o_out_of_lock_flag_out, o_out_of_lock_flag_oe, o_tone_out, o_tone_oe;
  logic [ADDR_W-1:0] i_s_axi_awaddr, i_s_axi_araddr;
  logic [31:0] i_s_axi_wdata, o_s_axi_rdata;
  logic [1:0] o_s_axi_bresp, o_s_axi_rresp;
  logic i_s_axi_awvalid, o_s_axi_awready, i_s_axi_wvalid, o_s_axi_wready, o_s_axi_bvalid, i_s_axi_bready;
  logic i_s_axi_arvalid, o_s_axi_arready, o_s_axi_rvalid, i_s_axi_rready;
  logic [31:0] seed = 32'h1CE6;
  int err_total = 0;
  int checks = 0;
  dual_loop_channel_synthesizer u_dual_loop_channel_synthesizer (.i_clk, .i_sys_rst, .i_mode,
    .i_standby_ctl, .i_chan_code, .i_ser_clk, .i_ser_data, .i_latch_strobe, .i_ref_osc_in, .i_rx_vco_in,
    .i_tx_vco_in, .o_ref_osc_out, .o_phase_err_a_out, .o_phase_err_a_oe, .o_phase_err_b_out,
    .o_phase_err_b_oe, .o_out_of_lock_flag_out, .o_out_of_lock_flag_oe, .o_tone_out, .o_tone_oe,
    .i_s_axi_awaddr, .i_s_axi_awvalid, .o_s_axi_awready, .i_s_axi_wdata, .i_s_axi_wstrb, .i_s_axi_wvalid,
    .o_s_axi_wready, .o_s_axi_bresp, .o_s_axi_bvalid, .i_s_axi_bready, .i_s_axi_araddr, .i_s_axi_arvalid,
    .o_s_axi_arready, .o_s_axi_rdata, .o_s_axi_rresp, .o_s_axi_rvalid, .i_s_axi_rready);
  synth_partner #(.REF_HALF(3)) u_synth_partner (.i_clk, .i_rx_run(rx_run), .i_tx_run(tx_run),
    .o_ref_osc(i_ref_osc_in), .o_rx_vco(i_rx_vco_in), .o_tx_vco(i_tx_vco_in), .o_ser_clk(i_ser_clk),
    .o_ser_data(i_ser_data), .o_strobe(i_latch_strobe));
  // ==========================================================================
  // Helpers
  // Clock at 25 MHz.
  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end
  function automatic logic [31:0] next_rand();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Expected divisor word for channels one to three and the channel-ten fallback.
  function automatic logic [31:0] exp_div(input logic m, input logic [3:0] c);
    logic [13:0] tx, rx;
    case (c)
      4'h1: {tx, rx} = m ? {14'h246A, 14'h1E73} : {14'h26CE, 14'h1C0F};
      4'h2: {tx, rx} = m ? {14'h246E, 14'h1E96} : {14'h26F1, 14'h1C13};
      4'h3: {tx, rx} = m ? {14'h2476, 14'h1E99} : {14'h26F4, 14'h1C1B};
      default: {tx, rx} = m ? {14'h24B2, 14'h1EAF} : {14'h270A, 14'h1C57};
    endcase
    return {2'h0, tx, 2'h0, rx};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // Write: address and data offered together, each released when taken.
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    i_s_axi_awaddr <= a;
    i_s_axi_wdata <= d;
    {i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_bready} <= 3'h7;
    fork
      begin
        do @(posedge i_clk); while (o_s_axi_awready !== 1'b1);
        i_s_axi_awvalid <= 1'b0;
      end
      begin
        do @(posedge i_clk); while (o_s_axi_wready !== 1'b1);
        i_s_axi_wvalid <= 1'b0;
      end
    join
    do @(posedge i_clk); while (o_s_axi_bvalid !== 1'b1);
    r = o_s_axi_bresp;
    i_s_axi_bready <= 1'b0;
    @(posedge i_clk);
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    i_s_axi_araddr <= a;
    {i_s_axi_arvalid, i_s_axi_rready} <= 2'h3;
    do @(posedge i_clk); while (o_s_axi_arready !== 1'b1);
    i_s_axi_arvalid <= 1'b0;
    do @(posedge i_clk); while (o_s_axi_rvalid !== 1'b1);
    d = o_s_axi_rdata;
    r = o_s_axi_rresp;
    i_s_axi_rready <= 1'b0;
    @(posedge i_clk);
  endtask
  task automatic close_out();
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // ==========================================================================
  // Watchdog
  // The run needs about 49000 cycles; a hang ends it with a mismatch.
  initial begin
    repeat (95000) @(posedge i_clk);
    err_total++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    close_out();
  end
  // ==========================================================================
  // Main sequence
  initial begin
    logic [31:0] d, n;
    logic [1:0] r;
    logic [3:0] c;
    {i_sys_rst, i_mode, i_standby_ctl, i_chan_code, rx_run, tx_run} = {1'b1, 8'h00};
    {i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_bready, i_s_axi_arvalid, i_s_axi_rready} = 5'h00;
    {i_s_axi_awaddr, i_s_axi_araddr, i_s_axi_wdata, i_s_axi_wstrb} = {16'h0000, 32'h0, 4'hF};
    repeat (20) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    repeat (2) @(posedge i_clk);
    axi_rd(REG_CTRL, d, r);
    chk(32'({d[0], r}), 32'({CTRL_SERIAL_RST, RESP_OKAY}), "ctrl reset");
    axi_rd(8'h0C, d, r);
    chk(d, 32'h0, "unmapped read data");
    chk(32'(r), 32'(RESP_SLVERR), "unmapped read resp");
    // Parallel codes: channels 1-3, 10 and an illegal code, in both modes.
    for (int i = 0; i < 10; i++) begin
      n = next_rand();
      c = (n[2:0] > 3'h4) ? 4'h0 : 4'hB + 4'(n[2:0]);
      c = (i % 5 == 4) ? c : ((i % 5 == 3) ? 4'hA : 4'(i % 5 + 1));
      i_mode <= (i >= 5);
      i_standby_ctl <= n[3];
      i_chan_code <= c;
      repeat (10) @(posedge i_clk);
      axi_rd(REG_DIV, d, r);
      chk(d, exp_div(i >= 5, c), "parallel divisors");
      axi_rd(REG_STATUS, d, r);
      chk(32'({d[10:9], d[7:4]}), 32'({i >= 5, n[3], (c == 4'h0 || c > 4'hA) ? 4'hA : c}), "status");
    end
    n = next_rand();
    axi_wr(REG_CTRL, {n[31:1], 1'b1}, r);
    chk(32'(r), 32'(RESP_OKAY), "ctrl write");
    axi_wr(8'h40, n, r);
    chk(32'(r), 32'(RESP_SLVERR), "unmapped write");
    // Serial codes with one extra leading bit; parallel pins show an illegal code.
    for (int i = 1; i <= 3; i++) begin
      n = next_rand();
      i_mode <= n[0];
      i_chan_code <= 4'h0;
      u_synth_partner.send_code({n[1], 4'(i)});
      repeat (4) @(posedge i_clk);
      axi_rd(REG_DIV, d, r);
      chk(d, exp_div(n[0], 4'(i)), "serial divisors");
    end
    // Tone: both halves last 1024 reference edges of six cycles each.
    rx_run <= 1'b1;
    do @(posedge i_clk); while (o_tone_oe !== 1'b0);
    do @(posedge i_clk); while (o_tone_oe !== 1'b1);
    chk(32'(o_tone_out), 32'h0, "tone pulls low");
    for (int k = 0; k < 2; k++) begin
      n = 0;
      do begin
        @(posedge i_clk);
        n++;
      end while (o_tone_oe === (k == 0));
      chk(n, 32'(TONE_HALF * 6), "tone half period");
    end
    // The oscillator output shows the inverse of the reference pin five edges later.
    d = 32'(i_ref_osc_in);
    repeat (5) @(posedge i_clk);
    chk(32'(o_ref_osc_out), 32'(!d[0]), "ref out");
    // Stalled VCOs lag the reference; standby low holds the transmit side quiet.
    rx_run <= 1'b0;
    i_standby_ctl <= 1'b0;
    repeat (REF_DIV * 6 + 20) @(posedge i_clk);
    chk(32'({o_phase_err_a_oe, o_phase_err_a_out}), 32'h3, "receive lag");
    chk(32'({o_phase_err_b_oe, o_out_of_lock_flag_oe}), 32'h0, "transmit in standby");
    i_standby_ctl <= 1'b1;
    repeat (REF_DIV * 6 + 20) @(posedge i_clk);
    chk(32'({o_phase_err_b_oe, o_phase_err_b_out, o_out_of_lock_flag_oe, o_out_of_lock_flag_out}), 32'hF,
      "transmit out of lock");
    close_out();
  end
endmodule
